// ===== hw/sda_stream_regs.vh
// Register map, field layout, reset values and timing counts of the stream delay block
`ifndef SDA_STREAM_REGS_VH
`define SDA_STREAM_REGS_VH

// ==========================================================================
// Register indices (byte address = 4 * index)
// ==========================================================================
`define SDA_CTRL_IDX       10'h000
`define SDA_BPD_IDX_FIRST  10'h063
`define SDA_BPD_IDX_LAST   10'h082
`define SDA_LOA_IDX_FIRST  10'h083
`define SDA_LOA_IDX_LAST   10'h0A2

// ==========================================================================
// Fields
// ==========================================================================
`define SDA_STREAMS        32
`define SDA_MODE_BIT       0
`define SDA_MODE_ACT_BIT   1
`define SDA_BPD_W          5
`define SDA_LOA_W          2

// ==========================================================================
// Reset values
// ==========================================================================
`define SDA_MODE_RST       1'h0
`define SDA_BPD_RST        5'h00
`define SDA_LOA_RST        2'h0

// ==========================================================================
// Timing
// ==========================================================================
// One clock is one quarter bit; a frame is 256 bits of 4 quarters
`define SDA_QCNT_W         10
`define SDA_QCNT_LAST      10'h3FF
`define SDA_FRAC_BASE      10'h003
`define SDA_SYNC_LAT       10'h002

// ==========================================================================
// Bus responses
// ==========================================================================
`define SDA_RESP_OKAY      2'h0
`define SDA_RESP_SLVERR    2'h2

`endif

// ===== hw/sda_stream_delay_adv.v
// Per-stream backplane input delay and local output advancement with AXI4-Lite registers
`include "sda_stream_regs.vh"

// Function
// R1: Five-bit delay field per backplane input stream
// R2: Mode low: delay is field/4 bits
// R3: Fractional delay only later, up to 7.75 bits
// R4: Fractional zero delay samples at 3/4 bit
// R5: Mode high: upper bits integer delay, lower sample point
// R6: Sample point decode 00=3/4,01=4/4,10=1/4,11=2/4
// R7: 32 local advancement registers, consecutive addresses
// R8: Advance outputs 0, 2, 4 or 6 cycles
// R9: Advance decode 00=0,01=2,10=4,11=6 cycles
// R10: Zero advance aligns with generated frame pulse
// R11: Advance field in bits 1:0, resets zero
// R12: Software writes zero to bits 15:2
// R13: One mode bit selects mode for all streams
// R14: Setting changes take effect at frame boundary
module sda_stream_delay_adv (
  input  wire        clk,
  input  wire        rst,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] bp_serial_in,
  output reg  [31:0] bp_rx_bit,
  output reg  [31:0] bp_rx_valid,
  output reg  [31:0] bp_rx_first,
  input  wire [31:0] lo_tx_bit,
  output wire [31:0] lo_tx_take,
  output wire [31:0] lo_tx_first,
  output reg  [31:0] local_serial_out_stream,
  output reg         generated_frame_pulse_out
);

  // ==========================================================================
  // Frame timing
  // ==========================================================================
  reg  [`SDA_QCNT_W-1:0] qcnt;
  wire                   frame_end;

  assign frame_end = (qcnt == `SDA_QCNT_LAST);

  always @(posedge clk) begin
    if (rst) begin
      qcnt                      <= {`SDA_QCNT_W{1'b0}};
      generated_frame_pulse_out <= 1'b0;
    end else begin
      qcnt                      <= qcnt + 10'h001;
      // High during quarter 0 of each frame except the first frame after reset
      generated_frame_pulse_out <= frame_end; // R10
    end
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  reg [31:0] bp_s1;
  reg [31:0] bp_s2;

  always @(posedge clk) begin
    if (rst) begin
      bp_s1 <= 32'h0000_0000;
      bp_s2 <= 32'h0000_0000;
    end else begin
      bp_s1 <= bp_serial_in;
      bp_s2 <= bp_s1;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  reg        aw_held;
  reg        w_held;
  reg [9:0]  aw_idx;
  reg [15:0] wr_data;
  reg        wr_lane0;
  wire       wr_fire;
  wire [9:0] wr_bpd_off;
  wire [9:0] wr_loa_off;
  wire       wr_bpd_hit;
  wire       wr_loa_hit;
  wire       wr_ctrl_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held;
  assign wr_bpd_off    = aw_idx - `SDA_BPD_IDX_FIRST;
  assign wr_loa_off    = aw_idx - `SDA_LOA_IDX_FIRST;
  assign wr_bpd_hit    = (aw_idx >= `SDA_BPD_IDX_FIRST) && (aw_idx <= `SDA_BPD_IDX_LAST);
  assign wr_loa_hit    = (aw_idx >= `SDA_LOA_IDX_FIRST) && (aw_idx <= `SDA_LOA_IDX_LAST); // R7
  assign wr_ctrl_hit   = (aw_idx == `SDA_CTRL_IDX);

  always @(posedge clk) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 10'h000;
      wr_data      <= 16'h0000;
      wr_lane0     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SDA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        wr_data  <= s_axi_wdata[15:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_bpd_hit || wr_loa_hit || wr_ctrl_hit) begin
          s_axi_bresp <= `SDA_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SDA_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Mode control, shared by all backplane streams
  // ==========================================================================
  reg mode_sel;
  reg mode_act;

  always @(posedge clk) begin
    if (rst) begin
      mode_sel <= `SDA_MODE_RST;
      mode_act <= `SDA_MODE_RST;
    end else begin
      if (wr_fire && wr_ctrl_hit && wr_lane0) begin
        mode_sel <= wr_data[`SDA_MODE_BIT]; // R13
      end
      if (frame_end) begin
        mode_act <= mode_sel; // R14
      end
    end
  end

  // ==========================================================================
  // Per-stream settings, input sampling and output advancement
  // ==========================================================================
  wire [32*`SDA_BPD_W-1:0] bpd_all;
  wire [32*`SDA_LOA_W-1:0] loa_all;

  genvar n;
  generate
    for (n = 0; n < `SDA_STREAMS; n = n + 1) begin : g_stream
      reg  [`SDA_BPD_W-1:0]  bpd;
      reg  [`SDA_BPD_W-1:0]  bpd_act;
      reg  [`SDA_LOA_W-1:0]  loa;
      reg  [`SDA_LOA_W-1:0]  loa_act;
      reg  [2:0]             smp_pt;
      wire [`SDA_QCNT_W-1:0] in_off;
      wire [`SDA_QCNT_W-1:0] in_rel;
      wire [`SDA_QCNT_W-1:0] out_rel;

      assign bpd_all[n*`SDA_BPD_W +: `SDA_BPD_W] = bpd;
      assign loa_all[n*`SDA_LOA_W +: `SDA_LOA_W] = loa;

      always @(posedge clk) begin
        if (rst) begin
          bpd     <= `SDA_BPD_RST;
          bpd_act <= `SDA_BPD_RST;
          loa     <= `SDA_LOA_RST; // R11
          loa_act <= `SDA_LOA_RST;
        end else begin
          if (wr_fire && wr_lane0 && wr_bpd_hit && (wr_bpd_off[4:0] == n)) begin
            bpd <= wr_data[`SDA_BPD_W-1:0]; // R1
          end
          if (wr_fire && wr_lane0 && wr_loa_hit && (wr_loa_off[4:0] == n)) begin
            // Bits 15:2 are not stored and read back as zero
            loa <= wr_data[`SDA_LOA_W-1:0]; // R11 R12
          end
          // Shadow copies change only between frames so no frame is torn
          if (frame_end) begin
            bpd_act <= bpd; // R14
            loa_act <= loa; // R14
          end
        end
      end

      // Sample point in quarters within the bit
      always @* begin
        case (bpd_act[1:0])
          2'b00:   smp_pt = 3'h3; // R6
          2'b01:   smp_pt = 3'h4; // R6
          2'b10:   smp_pt = 3'h1; // R6
          2'b11:   smp_pt = 3'h2; // R6
          default: smp_pt = 3'h3;
        endcase
      end

      // Sampling offset in quarters from the frame start
      assign in_off = mode_act ?
                      ({5'h00, bpd_act[4:2], 2'b00} + {7'h00, smp_pt}) : // R5
                      ({5'h00, bpd_act} + `SDA_FRAC_BASE); // R2 R3 R4
      // Synchroniser latency taken out so timing refers to the pin
      assign in_rel  = qcnt - in_off - `SDA_SYNC_LAT;

      always @(posedge clk) begin
        if (rst) begin
          bp_rx_bit[n]   <= 1'b0;
          bp_rx_valid[n] <= 1'b0;
          bp_rx_first[n] <= 1'b0;
        end else begin
          bp_rx_valid[n] <= (in_rel[1:0] == 2'b00); // R2
          bp_rx_first[n] <= (in_rel == 10'h000);
          if (in_rel[1:0] == 2'b00) begin
            bp_rx_bit[n] <= bp_s2[n];
          end
        end
      end

      // Output register updates one edge ahead, hence the extra one
      assign out_rel        = qcnt + 10'h001 + {7'h00, loa_act, 1'b0}; // R8 R9
      assign lo_tx_take[n]  = (out_rel[1:0] == 2'b00);
      assign lo_tx_first[n] = (out_rel == 10'h000); // R10

      always @(posedge clk) begin
        if (rst) begin
          local_serial_out_stream[n] <= 1'b0;
        end else if (lo_tx_take[n]) begin
          local_serial_out_stream[n] <= lo_tx_bit[n]; // R8
        end
      end
    end
  endgenerate

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  wire [9:0] rd_idx;
  wire [9:0] rd_bpd_off;
  wire [9:0] rd_loa_off;
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[11:2];
  assign rd_bpd_off    = rd_idx - `SDA_BPD_IDX_FIRST;
  assign rd_loa_off    = rd_idx - `SDA_LOA_IDX_FIRST;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_resp = `SDA_RESP_OKAY;
    if (rd_idx == `SDA_CTRL_IDX) begin
      rd_word[`SDA_MODE_BIT]     = mode_sel;
      rd_word[`SDA_MODE_ACT_BIT] = mode_act;
    end else if ((rd_idx >= `SDA_BPD_IDX_FIRST) && (rd_idx <= `SDA_BPD_IDX_LAST)) begin
      rd_word[`SDA_BPD_W-1:0] = bpd_all[rd_bpd_off[4:0]*`SDA_BPD_W +: `SDA_BPD_W];
    end else if ((rd_idx >= `SDA_LOA_IDX_FIRST) && (rd_idx <= `SDA_LOA_IDX_LAST)) begin
      rd_word[`SDA_LOA_W-1:0] = loa_all[rd_loa_off[4:0]*`SDA_LOA_W +: `SDA_LOA_W];
    end else begin
      rd_resp = `SDA_RESP_SLVERR;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SDA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sda_stream_delay_adv

// ===== test/sda_stream_delay_adv_props.sv
// Port checks of the stream delay block
module sda_props (
  input wire        clk,
  input wire        rst,
  input wire        generated_frame_pulse_out,
  input wire [31:0] bp_rx_first,
  input wire [31:0] bp_rx_valid,
  input wire [31:0] lo_tx_first,
  input wire [31:0] lo_tx_take,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [9:0] qc;
  reg       run;
  // Mirrors the frame position; run masks the first cycle after reset
  always @(posedge clk) begin
    qc  <= rst ? 10'h000 : qc + 10'h001;
    run <= !rst;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_frame_grid: assert property (generated_frame_pulse_out == (run && qc == 10'h000))
    else $error("frame pulse off grid");
  a_rx_first_win: assert property (|bp_rx_first |-> qc >= 10'h004 && qc <= 10'h025)
    else $error("input frame start out of range");
  a_first_valid: assert property ((bp_rx_first & ~bp_rx_valid) == 32'h0)
    else $error("first without valid");
  a_tx_first_win: assert property (|lo_tx_first |-> qc[0] && qc >= 10'h3F9)
    else $error("advance out of range");
  a_first_take: assert property ((lo_tx_first & ~lo_tx_take) == 32'h0)
    else $error("first without take");
  a_take_odd: assert property (run && |lo_tx_take |-> qc[0])
    else $error("take off even advance grid");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_rd_reserved: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved bits set");
endmodule // sda_props

bind sda_stream_delay_adv sda_props sda_props_i (.*);

// ===== test/sda_tdm_far_end.sv
// Far-end serial devices on the backplane inputs and local outputs
module sda_tdm_far_end (
  input  wire        clk,
  input  wire        generated_frame_pulse_out,
  input  wire [31:0] lo_tx_first,
  output wire [31:0] bp_serial_in,
  output wire [31:0] lo_tx_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [9:0] q = 10'h000;
  always @(posedge clk) q <= generated_frame_pulse_out ? 10'h001 : q + 10'h001;
  // Level follows the bit index, so a two-bit shift shows
  assign bp_serial_in = {32{q[2] ^ q[3]}};
  // Only frame bit 0 is high: its edge times each stream
  assign lo_tx_bit = lo_tx_first;
endmodule // sda_tdm_far_end

// ===== test/sda_stream_delay_adv_tb_top.sv
// Self-checking bench of the stream delay block
module sda_stream_delay_adv_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk = 1'h0, rst = 1'h1;
  reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  wire [3:0]  s_axi_wstrb = 4'hF;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        generated_frame_pulse_out;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, bp_serial_in, bp_rx_bit, bp_rx_valid, bp_rx_first;
  wire [31:0] lo_tx_bit, lo_tx_take, lo_tx_first, local_serial_out_stream;
  integer     n_mismatch = 0, cmp_count = 0, fq [0:31], rq [0:31], vc [0:31];
  reg  [31:0] fb;
  sda_stream_delay_adv sda_stream_delay_adv_i (.*);
  sda_tdm_far_end sda_tdm_far_end_i (.*);
  always #10 clk = ~clk;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("%0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // One bus access; for a read d is the expected data
  task xfer(input w, input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      check(w ? s_axi_bresp : s_axi_rresp, er);
      if (!w) check(s_axi_rdata, d);
    end
  endtask
  // Records one frame: input frame starts and output rising edges
  task obs;
    integer q, n;
    reg [31:0] prev;
    begin
      @(posedge clk);
      while (generated_frame_pulse_out !== 1'h1) @(posedge clk);
      prev = local_serial_out_stream;
      for (n = 0; n < 32; n = n + 1) begin
        fq[n] = -1;
        rq[n] = -1;
        vc[n] = 0;
      end
      for (q = 1; q <= 1024; q = q + 1) begin
        @(posedge clk);
        for (n = 0; n < 32; n = n + 1) begin
          if (bp_rx_first[n] === 1'h1) fq[n] = q;
          if (bp_rx_valid[n] === 1'h1) vc[n] = vc[n] + 1;
          if (bp_rx_first[n] === 1'h1) fb[n] = bp_rx_bit[n];
          if ({local_serial_out_stream[n], prev[n]} === 2'h2) rq[n] = q % 1024;
        end
        prev = local_serial_out_stream;
      end
    end
  endtask
  function integer offs(input m, input [4:0] f);
    offs = !m ? 3 + f : 4 * f[4:2] + (f[1:0] == 2'h0 ? 3 : f[1:0] == 2'h1 ? 4 : f[1:0] - 1);
  endfunction
  task s_reset_map;
    begin
      xfer(1'h0, 12'h000, 32'h0, 2'h0);
      xfer(1'h0, 12'h18C, 32'h0, 2'h0);
      xfer(1'h0, 12'h288, 32'h0, 2'h0);
      xfer(1'h0, 12'h28C, 32'h0, 2'h2);
      xfer(1'h1, 12'h28C, 32'h3, 2'h2);
    end
  endtask
  // Settings land at a frame boundary, so the first frame seen may be stale
  task s_out_advance;
    integer n;
    begin
      for (n = 0; n < 32; n = n + 1) xfer(1'h1, 12'h20C + 12'(4 * n), n % 4, 2'h0);
      for (n = 0; n < 32; n = n + 1) xfer(1'h0, 12'h20C + 12'(4 * n), n % 4, 2'h0);
      obs;
      obs;
      for (n = 0; n < 32; n = n + 1) check(rq[n], (1024 - 2 * (n % 4)) % 1024);
    end
  endtask
  task s_in_delay(input m);
    integer n, o;
    begin
      xfer(1'h1, 12'h000, {31'h0, m}, 2'h0);
      for (n = 0; n < 32; n = n + 1) xfer(1'h1, 12'h18C + 12'(4 * n), n, 2'h0);
      obs;
      obs;
      xfer(1'h0, 12'h000, {30'h0, m, m}, 2'h0);
      for (n = 0; n < 32; n = n + 1) begin
        o = offs(m, n[4:0]);
        check(fq[n], o + 3);
        check(vc[n], 256);
        check(fb[n], o[2] ^ o[3]);
      end
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    s_reset_map;
    s_out_advance;
    s_in_delay(1'h0);
    s_in_delay(1'h1);
    print_verdict;
  end
endmodule // sda_stream_delay_adv_tb_top
